// *** src/mdr_pkg.sv ***
package mdr_pkg;
   localparam int          DATA_AW      = 8;
   localparam int          PROG_AW      = 12;
   localparam int          STACK_DEPTH  = 6;
   localparam logic [7:0]  RAM_BASE     = 8'h00;
   localparam logic [7:0]  RAM_LAST     = 8'h3f;
   localparam logic [7:0]  WIN_BASE     = 8'h40;
   localparam logic [7:0]  WIN_LAST     = 8'h7f;
   localparam logic [7:0]  CORE_BASE    = 8'h80;
   localparam logic [7:0]  CORE_LAST    = 8'h83;
   localparam logic [7:0]  PA_DATA      = 8'hc0;
   localparam logic [7:0]  PB_DATA      = 8'hc1;
   localparam logic [7:0]  PA_DIR       = 8'hc4;
   localparam logic [7:0]  PB_DIR       = 8'hc5;
   localparam logic [7:0]  INT_OPT      = 8'hc8;
   localparam logic [7:0]  WIN_SEL      = 8'hc9;
   localparam logic [7:0]  PA_OPT       = 8'hcc;
   localparam logic [7:0]  PB_OPT       = 8'hcd;
   localparam logic [7:0]  CONV_RES     = 8'hd0;
   localparam logic [7:0]  CONV_CTL     = 8'hd1;
   localparam logic [7:0]  TMR_PSC      = 8'hd2;
   localparam logic [7:0]  TMR_CNT      = 8'hd3;
   localparam logic [7:0]  TMR_STAT     = 8'hd4;
   localparam logic [7:0]  WDG_CTL      = 8'hd8;
   localparam logic [7:0]  ACCUM        = 8'hff;
   localparam logic [7:0]  PORT_RST     = 8'h00;
   localparam logic [7:0]  CONV_CTL_RST = 8'h40;
   localparam logic [7:0]  TMR_PSC_RST  = 8'h7f;
   localparam logic [7:0]  TMR_CNT_RST  = 8'hff;
   localparam logic [7:0]  TMR_STAT_RST = 8'h00;
   localparam logic [7:0]  WDG_RST      = 8'hfe;
   localparam logic [7:0]  UNDEF_RD     = 8'h00;
   localparam logic [7:0]  CONV_RO_MASK = 8'hc0;
   localparam logic [7:0]  CONV_WO_MASK = 8'h3f;
   localparam logic [11:0] PC_RST       = 12'h000;
   localparam logic [11:0] PROT_RD      = 12'h000;
endpackage

// *** src/mdr_data_space.sv ***
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/100ps
module mdr_data_space #(
   parameter bit HAS_CONV = 1'b1,
   parameter int PORTA_W  = 4,
   parameter int PORTB_W  = 8
) (
   input  wire logic                                ref_clk,
   input  wire logic                                rst,
   input  wire logic                                wb_cyc_i,
   input  wire logic                                wb_stb_i,
   input  wire logic                                wb_we_i,
   input  wire logic [mdr_pkg::DATA_AW-1:0]         wb_adr_i,
   input  wire logic [7:0]                          wb_dat_i,
   input  wire logic                                wb_sel_i,
   output logic [7:0]                               wb_dat_o,
   output logic                                     wb_ack_o,
   input  wire logic [7:0]                          romData,
   output logic [mdr_pkg::PROG_AW-1:0]              romAdr,
   input  wire logic [mdr_pkg::PROG_AW-1:0]         extRdAdr,
   input  wire logic                                extRdReq,
   output logic [7:0]                               extRdData,
   output logic                                     extRdRefused,
   input  wire logic                                readoutProtect,
   input  wire logic                                fullErase,
   output logic                                     eraseClear,
   input  wire logic                                pcLoad,
   input  wire logic [mdr_pkg::PROG_AW-1:0]         pcLoadVal,
   input  wire logic                                pcInc,
   input  wire logic                                stackPush,
   input  wire logic                                stackPop,
   output logic [mdr_pkg::PROG_AW-1:0]              programCounter,
   output logic                                     stackFull,
   input  wire logic [7:0]                          portAPin,
   input  wire logic [7:0]                          portBPin,
   output logic [7:0]                               portADir,
   output logic [7:0]                               portBDir,
   output logic [7:0]                               portAOpt,
   output logic [7:0]                               portBOpt,
   output logic [7:0]                               portALatch,
   output logic [7:0]                               portBLatch,
   output logic [7:0]                               interruptOption,
   output logic [7:0]                               converterControl,
   input  wire logic [7:0]                          convResult,
   input  wire logic [1:0]                          convStatus,
   output logic [7:0]                               timerPrescaler,
   output logic [7:0]                               timerDowncounter,
   output logic [7:0]                               timerStatusControl,
   output logic [7:0]                               watchdogControl
);
   logic [7:0]  coreRegs_r [4];
   logic [7:0]  accum_r;
   logic [7:0]  ram_r [64];
   logic [5:0]  winSel_r;
   logic [11:0] stack_r [mdr_pkg::STACK_DEPTH];
   logic [2:0]  sp_r;
   logic [7:0]  rdData_nxt;
   logic        access;
   logic        wrEn;
   logic        convHit;

   assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wrEn   = access && wb_we_i && wb_sel_i;
   assign convHit = HAS_CONV &&
                    (wb_adr_i == mdr_pkg::CONV_RES || wb_adr_i == mdr_pkg::CONV_CTL);
   assign stackFull = (sp_r == 3'(mdr_pkg::STACK_DEPTH));

   // Program counter, separate program space address
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         programCounter <= mdr_pkg::PC_RST;
      end else if (pcLoad) begin
         programCounter <= pcLoadVal;
      end else if (stackPop && sp_r != 3'h0) begin
         programCounter <= stack_r[sp_r - 3'h1];
      end else if (pcInc) begin
         programCounter <= programCounter + 12'h001;
      end
   end

   // Stack space: six entries, pushes beyond six are dropped
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sp_r <= 3'h0;
      end else if (stackPush && !stackFull) begin
         sp_r <= sp_r + 3'h1;
      end else if (stackPop && !stackPush && sp_r != 3'h0) begin
         sp_r <= sp_r - 3'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (stackPush && !stackFull) begin
         stack_r[sp_r] <= programCounter;
      end
   end

   // Program space port: window read from data bus, else external read
   always_comb begin
      if (access && wb_adr_i >= mdr_pkg::WIN_BASE && wb_adr_i <= mdr_pkg::WIN_LAST) begin
         romAdr = {winSel_r, wb_adr_i[5:0]};
      end else begin
         romAdr = extRdAdr;
      end
   end

   assign extRdRefused = extRdReq && readoutProtect;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         extRdData <= 8'h00;
      end else if (extRdReq) begin
         extRdData <= readoutProtect ? mdr_pkg::UNDEF_RD : romData;
      end
   end

   // Protection lifts only with erase; the erase wipes program memory
   assign eraseClear = fullErase;

   // RAM and core registers, undefined at reset
   always_ff @(posedge ref_clk) begin
      if (wrEn && wb_adr_i <= mdr_pkg::RAM_LAST) begin
         ram_r[wb_adr_i[5:0]] <= wb_dat_i;
      end
      if (wrEn && wb_adr_i >= mdr_pkg::CORE_BASE && wb_adr_i <= mdr_pkg::CORE_LAST) begin
         coreRegs_r[wb_adr_i[1:0]] <= wb_dat_i;
      end
      if (wrEn && wb_adr_i == mdr_pkg::ACCUM) begin
         accum_r <= wb_dat_i;
      end
      if (wrEn && wb_adr_i == mdr_pkg::INT_OPT) begin
         interruptOption <= wb_dat_i;
      end
      if (wrEn && wb_adr_i == mdr_pkg::WIN_SEL) begin
         winSel_r <= wb_dat_i[5:0];
      end
   end

   // Port registers: all inputs with pull-up after reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         portALatch <= mdr_pkg::PORT_RST;
         portBLatch <= mdr_pkg::PORT_RST;
         portADir   <= mdr_pkg::PORT_RST;
         portBDir   <= mdr_pkg::PORT_RST;
         portAOpt   <= mdr_pkg::PORT_RST;
         portBOpt   <= mdr_pkg::PORT_RST;
      end else if (wrEn) begin
         unique case (wb_adr_i)
            mdr_pkg::PA_DATA: portALatch <= wb_dat_i;
            mdr_pkg::PB_DATA: portBLatch <= wb_dat_i;
            mdr_pkg::PA_DIR:  portADir   <= wb_dat_i;
            mdr_pkg::PB_DIR:  portBDir   <= wb_dat_i;
            mdr_pkg::PA_OPT:  portAOpt   <= wb_dat_i;
            mdr_pkg::PB_OPT:  portBOpt   <= wb_dat_i;
            default: ;
         endcase
      end
   end

   // Converter, timer and watchdog registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         converterControl   <= mdr_pkg::CONV_CTL_RST;
         timerPrescaler     <= mdr_pkg::TMR_PSC_RST;
         timerDowncounter   <= mdr_pkg::TMR_CNT_RST;
         timerStatusControl <= mdr_pkg::TMR_STAT_RST;
         watchdogControl    <= mdr_pkg::WDG_RST;
      end else if (wrEn) begin
         if (convHit && wb_adr_i == mdr_pkg::CONV_CTL) begin
            converterControl <= (converterControl & mdr_pkg::CONV_RO_MASK) |
                                (wb_dat_i & mdr_pkg::CONV_WO_MASK);
         end
         if (wb_adr_i == mdr_pkg::TMR_PSC) timerPrescaler <= wb_dat_i;
         if (wb_adr_i == mdr_pkg::TMR_CNT) timerDowncounter <= wb_dat_i;
         if (wb_adr_i == mdr_pkg::TMR_STAT) timerStatusControl <= wb_dat_i;
         if (wb_adr_i == mdr_pkg::WDG_CTL) watchdogControl <= wb_dat_i;
      end
   end

   // Read multiplexer
   always_comb begin
      rdData_nxt = mdr_pkg::UNDEF_RD;
      if (wb_adr_i <= mdr_pkg::RAM_LAST) begin
         rdData_nxt = ram_r[wb_adr_i[5:0]];
      end else if (wb_adr_i <= mdr_pkg::WIN_LAST) begin
         rdData_nxt = romData;
      end else if (wb_adr_i <= mdr_pkg::CORE_LAST) begin
         rdData_nxt = coreRegs_r[wb_adr_i[1:0]];
      end else begin
         unique case (wb_adr_i)
            mdr_pkg::PA_DATA:  rdData_nxt = (portALatch & portADir) | (portAPin & ~portADir);
            mdr_pkg::PB_DATA:  rdData_nxt = (portBLatch & portBDir) | (portBPin & ~portBDir);
            mdr_pkg::PA_DIR:   rdData_nxt = portADir;
            mdr_pkg::PB_DIR:   rdData_nxt = portBDir;
            mdr_pkg::PA_OPT:   rdData_nxt = portAOpt;
            mdr_pkg::PB_OPT:   rdData_nxt = portBOpt;
            mdr_pkg::CONV_RES: rdData_nxt = convHit ? convResult : mdr_pkg::UNDEF_RD;
            mdr_pkg::CONV_CTL: rdData_nxt = convHit ? {convStatus, 6'h00} : mdr_pkg::UNDEF_RD;
            mdr_pkg::TMR_PSC:  rdData_nxt = timerPrescaler;
            mdr_pkg::TMR_CNT:  rdData_nxt = timerDowncounter;
            mdr_pkg::TMR_STAT: rdData_nxt = timerStatusControl;
            mdr_pkg::WDG_CTL:  rdData_nxt = watchdogControl;
            mdr_pkg::ACCUM:    rdData_nxt = accum_r;
            default:           rdData_nxt = mdr_pkg::UNDEF_RD;
         endcase
      end
   end

   // Wishbone slave: one-cycle answer
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 8'h00;
      end else begin
         wb_ack_o <= access;
         if (access && !wb_we_i) begin
            wb_dat_o <= rdData_nxt;
         end
      end
   end

   a_ack_one_cycle: assert property (@(posedge ref_clk) disable iff (rst)
      access |=> wb_ack_o ##1 !wb_ack_o) else $error("Ack not one cycle");
   a_watchdog_write: assert property (@(posedge ref_clk) disable iff (rst)
      wrEn && wb_adr_i == mdr_pkg::WDG_CTL |=> watchdogControl == $past(wb_dat_i))
      else $error("Watchdog write lost");
   a_timer_write: assert property (@(posedge ref_clk) disable iff (rst)
      wrEn && wb_adr_i == mdr_pkg::TMR_PSC |=> timerPrescaler == $past(wb_dat_i))
      else $error("Prescaler write lost");
   a_port_input_read: assert property (@(posedge ref_clk) disable iff (rst)
      access && !wb_we_i && wb_adr_i == mdr_pkg::PA_DATA && portADir == 8'h00
      |=> wb_dat_o == $past(portAPin)) else $error("Input pin read wrong");
   a_dir_write: assert property (@(posedge ref_clk) disable iff (rst)
      wrEn && wb_adr_i == mdr_pkg::PB_DIR |=> portBDir == $past(wb_dat_i))
      else $error("Direction write lost");
   a_protect_refuse: assert property (@(posedge ref_clk) disable iff (rst)
      extRdReq && readoutProtect |=> extRdData == mdr_pkg::UNDEF_RD)
      else $error("Protected read leaked");
   a_stack_limit: assert property (@(posedge ref_clk) disable iff (rst)
      sp_r <= 3'(mdr_pkg::STACK_DEPTH)) else $error("Stack overflow");
   a_reserved_read: assert property (@(posedge ref_clk) disable iff (rst)
      access && !wb_we_i && wb_adr_i == 8'hc2 |=> wb_dat_o == mdr_pkg::UNDEF_RD)
      else $error("Reserved read not zero");
   a_window_addr: assert property (@(posedge ref_clk) disable iff (rst)
      access && wb_adr_i == mdr_pkg::WIN_BASE |-> romAdr[5:0] == 6'h00)
      else $error("Window address wrong");
   c_read_cycle: cover property (@(posedge ref_clk) access && !wb_we_i ##1 wb_ack_o);
   c_write_cycle: cover property (@(posedge ref_clk) wrEn ##1 wb_ack_o);
   c_stack_full: cover property (@(posedge ref_clk) stackFull);
endmodule

// *** verification/mdr_data_space_tb.sv ***
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin nMismatch++; \
   $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module mdr_data_space_tb;
   logic        ref_clk, rst, wbCyc, wbStb, wbWe, wbSel, wbAck, extRdReq, readoutProtect;
   logic        fullErase, eraseClear, extRdRefused, pcLoad, pcInc, stackPush, stackPop;
   logic        stackFull;
   logic [7:0]  wbAdr, wbDatW, wbDatR, romData, extRdData, portAPin, portBPin, q;
   logic [7:0]  portADir, portBDir, portAOpt, portBOpt, portALatch, portBLatch;
   logic [7:0]  interruptOption, converterControl, convResult, timerPrescaler;
   logic [7:0]  timerDowncounter, timerStatusControl, watchdogControl;
   logic [11:0] romAdr, extRdAdr, pcLoadVal, programCounter;
   logic [1:0]  convStatus;
   int          nMismatch, comparisons;
   // Address, write data, expected read back
   localparam logic [23:0] ROWS [20] = '{
      {mdr_pkg::PA_DIR, 16'h0a0a}, {mdr_pkg::PB_DIR, 16'ha5a5}, {mdr_pkg::PA_OPT, 16'h0c0c},
      {mdr_pkg::PB_OPT, 16'hc3c3}, {mdr_pkg::TMR_PSC, 16'h1212}, {mdr_pkg::TMR_CNT, 16'h3434},
      {mdr_pkg::TMR_STAT, 16'h5656}, {mdr_pkg::WDG_CTL, 16'h7878}, {mdr_pkg::CORE_BASE, 16'h1111},
      {mdr_pkg::CORE_LAST, 16'h2222}, {mdr_pkg::ACCUM, 16'h3333}, {mdr_pkg::RAM_BASE, 16'h4444},
      {mdr_pkg::RAM_LAST, 16'h5555}, 24'hc2ff00, 24'hd5ff00, 24'hd9ff00, 24'hfeff00,
      {mdr_pkg::INT_OPT, 16'h0f00}, {mdr_pkg::CONV_CTL, 16'hff80}, {mdr_pkg::CONV_RES, 16'h009c}};

   mdr_data_space mdr_data_space_i (
      .ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_sel_i(wbSel), .wb_dat_o(wbDatR),
      .wb_ack_o(wbAck), .romData(romData), .romAdr(romAdr), .extRdAdr(extRdAdr),
      .extRdReq(extRdReq), .extRdData(extRdData), .extRdRefused(extRdRefused),
      .readoutProtect(readoutProtect), .fullErase(fullErase), .eraseClear(eraseClear),
      .pcLoad(pcLoad), .pcLoadVal(pcLoadVal), .pcInc(pcInc), .stackPush(stackPush),
      .stackPop(stackPop), .programCounter(programCounter), .stackFull(stackFull),
      .portAPin(portAPin), .portBPin(portBPin), .portADir(portADir), .portBDir(portBDir),
      .portAOpt(portAOpt), .portBOpt(portBOpt), .portALatch(portALatch),
      .portBLatch(portBLatch), .interruptOption(interruptOption),
      .converterControl(converterControl), .convResult(convResult), .convStatus(convStatus),
      .timerPrescaler(timerPrescaler), .timerDowncounter(timerDowncounter),
      .timerStatusControl(timerStatusControl), .watchdogControl(watchdogControl));

   // Program memory model
   assign romData = romAdr[7:0] ^ 8'h5a;

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge ref_clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= w;
      wbAdr <= a;
      wbDatW <= d;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      if (n >= 20) begin
         nMismatch++;
         $display("mismatch ack expected 1 seen %b", wbAck);
      end
      q = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask

   task automatic chkReset;
      #1;
      `CHK("ports", {portADir, portBDir, portAOpt, portBOpt, portALatch, portBLatch}, 48'h0)
      `CHK("conv ctl", converterControl, mdr_pkg::CONV_CTL_RST)
      `CHK("timer", {timerPrescaler, timerDowncounter, timerStatusControl}, 24'h7fff00)
      `CHK("watchdog", watchdogControl, 8'hfe)
      `CHK("pc", programCounter, 12'h000)
   endtask

   task automatic wrapUp;
      $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
      if (nMismatch == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      #(40 * 20000);
      nMismatch++;
      wrapUp;
   end

   initial begin
      {wbCyc, wbStb, wbWe, extRdReq, readoutProtect, fullErase, pcLoad, pcInc} = 8'h00;
      {stackPush, stackPop, wbAdr, wbDatW} = 18'h0;
      wbSel = 1'b1;
      {portAPin, portBPin, pcLoadVal, extRdAdr} = 40'h0;
      convResult = 8'h9c;
      convStatus = 2'b10;
      rst = 1'b1;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      chkReset;
      for (int i = 0; i < 20; i++) begin
         xfer(1'b1, ROWS[i][23:16], ROWS[i][15:8]);
         xfer(1'b0, ROWS[i][23:16], 8'h00);
         `CHK("row read", q, ROWS[i][7:0])
      end
      `CHK("int opt", interruptOption, 8'h0f)
      `CHK("conv ctl", converterControl, 8'h7f)
      `CHK("dir out", {portADir, portBOpt}, 16'h0ac3)
      portAPin <= 8'h3c;
      portBPin <= 8'h96;
      xfer(1'b1, mdr_pkg::PA_DIR, 8'h0f);
      xfer(1'b1, mdr_pkg::PA_DATA, 8'h05);
      xfer(1'b1, mdr_pkg::PB_DIR, 8'h00);
      xfer(1'b0, mdr_pkg::PA_DATA, 8'h00);
      `CHK("port a read", q, 8'h35)
      `CHK("port a latch", portALatch, 8'h05)
      xfer(1'b0, mdr_pkg::PB_DATA, 8'h00);
      `CHK("port b read", q, 8'h96)
      xfer(1'b1, mdr_pkg::WIN_SEL, 8'h03);
      xfer(1'b0, 8'h45, 8'h00);
      `CHK("window", q, 8'h9f)
      @(posedge ref_clk);
      extRdReq <= 1'b1;
      readoutProtect <= 1'b1;
      #1 `CHK("refused", extRdRefused, 1'b1)
      @(posedge ref_clk);
      readoutProtect <= 1'b0;
      fullErase <= 1'b1;
      #1 `CHK("refused", extRdRefused, 1'b0)
      `CHK("protected data", extRdData, mdr_pkg::UNDEF_RD)
      `CHK("erase", eraseClear, 1'b1)
      @(posedge ref_clk);
      {fullErase, extRdReq, pcLoad} <= 3'b001;
      pcLoadVal <= 12'hffe;
      #1 `CHK("open data", extRdData, 8'h5a)
      @(posedge ref_clk);
      {pcLoad, pcInc} <= 2'b01;
      #1 `CHK("pc load", programCounter, 12'hffe)
      @(posedge ref_clk);
      #1 `CHK("pc inc", programCounter, 12'hfff)
      @(posedge ref_clk);
      pcInc <= 1'b0;
      stackPush <= 1'b1;
      #1 `CHK("pc wrap", programCounter, 12'h000)
      repeat (5) @(posedge ref_clk);
      #1 `CHK("stack five", stackFull, 1'b0)
      @(posedge ref_clk);
      stackPush <= 1'b0;
      stackPop <= 1'b1;
      #1 `CHK("stack six", stackFull, 1'b1)
      @(posedge ref_clk);
      stackPop <= 1'b0;
      #1 `CHK("stack pop", stackFull, 1'b0)
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chkReset;
      @(posedge ref_clk);
      rst <= 1'b0;
      xfer(1'b0, mdr_pkg::TMR_PSC, 8'h00);
      `CHK("psc read", q, 8'h7f)
      xfer(1'b0, mdr_pkg::PA_DATA, 8'h00);
      `CHK("input pins", q, 8'h3c)
      wrapUp;
   end
endmodule
